/* File: src/dual_channel_torque_off_monitor.sv */
// Summary of operation
// - both channels present: start runs, confirm off
// - single channel loss while running removes torque
// - withdrawal cuts torque at once, no ramp
// - any withdrawal raises trip without delay
// - single withdrawal keeps confirm output off
// - after short loss, start clears trip, runs
// - discrepancy beyond threshold sets fault latch
// - fault latched: start never runs motor
// - fault latched: trip stays, confirm off
// - only power cycle clears fault latch
// - paired withdrawal within window asserts confirm
// - both withdrawn: no start, trip immediate
// - confirm held while both withdrawn
// - both restored: confirm drops at once
// - after paired withdrawal, start clears trip
// - stop with channels present decelerates, confirm off
// - trip persists until a start command
// - torque removed within ten milliseconds
`timescale 1ns/1ps
`include "dcto_params.svh"

module dual_channel_torque_off_monitor
#(
   parameter int unsigned PAIR_WINDOW_CYCLES =
      int'(`DCTO_PAIR_WINDOW_CYCLES),
   parameter int unsigned DISCREPANCY_CYCLES =
      int'(`DCTO_DISCREPANCY_CYCLES),
   parameter logic [`DCTO_SPEED_W-1:0] RAMP_STEP = `DCTO_RAMP_STEP
)
(
   // clock and power-on reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // demand channels, high while present
   input wire logic i_demand_channel_a,
   input wire logic i_demand_channel_b,
   // operator commands
   input wire logic i_run_cmd,
   input wire logic [`DCTO_SPEED_W-1:0] i_test_speed_setpoint,
   // power stage
   output logic o_torque_enable,
   output logic [`DCTO_SPEED_W-1:0] o_speed_ref,
   output logic o_running,
   // status
   output logic o_torque_removal_trip,
   output logic o_fault_latched,
   output logic o_confirm_output_pos,
   output logic o_confirm_output_neg
);

   dcto_pkg::monitor_t cur;
   dcto_pkg::monitor_t next_cur;

   logic [1:0] chan_sync;
   logic chan_a;
   logic chan_b;
   logic both_present;
   logic none_present;
   logic mismatch;
   logic over_window;
   logic expired;
   logic start_edge;
   logic may_start;

   // ========================================
   // input synchronisation and discrepancy timing
   demand_sync
   #(
      .WIDTH(2)
   )
   u_sync
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_async({i_demand_channel_b, i_demand_channel_a}),
      .o_sync(chan_sync)
   );

   assign chan_a = chan_sync[0];
   assign chan_b = chan_sync[1];
   assign both_present = chan_a & chan_b;
   assign none_present = !chan_a & !chan_b;
   assign mismatch = chan_a ^ chan_b;

   discrepancy_timer
   #(
      .WINDOW_CYCLES(PAIR_WINDOW_CYCLES),
      .LIMIT_CYCLES(DISCREPANCY_CYCLES)
   )
   u_timer
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_mismatch(mismatch),
      .o_over_window(over_window),
      .o_expired(expired)
   );

   // run command is a level; only its rising edge starts
   assign start_edge = i_run_cmd & !cur.run_prev;
   assign may_start = start_edge & both_present & !cur.fault;

   // ========================================
   // sequencer
   always_comb
   begin
      next_cur = cur;
      next_cur.run_prev = i_run_cmd;
      // latch has no clear path; reset is the power cycle
      next_cur.fault = cur.fault | expired;
      if (both_present)
      begin
         next_cur.slow_pair = 1'b0;
      end
      else if (mismatch & over_window)
      begin
         // late second withdrawal: no confirmation
         next_cur.slow_pair = 1'b1;
      end
      unique case (cur.state)
         dcto_pkg::ST_IDLE,
         dcto_pkg::ST_TRIP:
         begin
            if (may_start)
            begin
               next_cur.state = dcto_pkg::ST_RUN;
               next_cur.trip = 1'b0;
               next_cur.speed = i_test_speed_setpoint;
            end
         end
         dcto_pkg::ST_RUN:
         begin
            next_cur.speed = i_test_speed_setpoint;
            if (!i_run_cmd)
            begin
               next_cur.state = dcto_pkg::ST_DECEL;
            end
         end
         dcto_pkg::ST_DECEL:
         begin
            if (start_edge)
            begin
               next_cur.state = dcto_pkg::ST_RUN;
               next_cur.speed = i_test_speed_setpoint;
            end
            else if (cur.speed <= RAMP_STEP)
            begin
               next_cur.speed = `DCTO_SPEED_RST;
               next_cur.state = dcto_pkg::ST_IDLE;
            end
            else
            begin
               next_cur.speed = cur.speed - RAMP_STEP;
            end
         end
         dcto_pkg::ST_FAULT:
         begin
            next_cur.speed = `DCTO_SPEED_RST;
         end
         default:
         begin
            next_cur.state = dcto_pkg::ST_FAULT;
            next_cur.speed = `DCTO_SPEED_RST;
         end
      endcase
      // withdrawal overrides all but a latched fault, including a start
      if (!both_present)
      begin
         next_cur.state = dcto_pkg::ST_TRIP;
         next_cur.trip = 1'b1;
         next_cur.speed = `DCTO_SPEED_RST;
      end
      if (next_cur.fault)
      begin
         next_cur.state = dcto_pkg::ST_FAULT;
         next_cur.trip = 1'b1;
         next_cur.speed = `DCTO_SPEED_RST;
      end
      // confirmation only for a clean paired withdrawal
      next_cur.confirm = none_present & !next_cur.fault &
         !next_cur.slow_pair;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         cur.state <= dcto_pkg::ST_IDLE;
         cur.trip <= 1'b0;
         cur.fault <= 1'b0;
         cur.slow_pair <= 1'b0;
         cur.confirm <= 1'b0;
         // a run held through power-up needs a fresh rising edge
         cur.run_prev <= 1'b1;
         cur.speed <= `DCTO_SPEED_RST;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   // ========================================
   // outputs
   assign o_torque_enable = (cur.state == dcto_pkg::ST_RUN) ||
      (cur.state == dcto_pkg::ST_DECEL);
   assign o_running = (cur.state == dcto_pkg::ST_RUN);
   assign o_speed_ref = cur.speed;
   assign o_torque_removal_trip = cur.trip;
   assign o_fault_latched = cur.fault;
   assign o_confirm_output_pos = cur.confirm;
   assign o_confirm_output_neg = cur.confirm;

   // ========================================
   // checks
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   property p_start_runs;
      may_start && ((cur.state == dcto_pkg::ST_IDLE) ||
         (cur.state == dcto_pkg::ST_TRIP))
      |=> o_running && !o_confirm_output_pos && !o_torque_removal_trip;
   endproperty
   a_start_runs: assert property (p_start_runs)
      else $error("start with both channels did not run");

   property p_loss_cuts;
      o_torque_enable && !both_present |=> !o_torque_enable &&
         (o_speed_ref == `DCTO_SPEED_RST);
   endproperty
   a_loss_cuts: assert property (p_loss_cuts)
      else $error("torque not removed on channel loss");

   property p_trip_raised;
      !both_present |=> o_torque_removal_trip;
   endproperty
   a_trip_raised: assert property (p_trip_raised)
      else $error("trip not raised on withdrawal");

   property p_single_no_confirm;
      mismatch |=> !o_confirm_output_pos && !o_confirm_output_neg;
   endproperty
   a_single_no_confirm: assert property (p_single_no_confirm)
      else $error("confirm asserted on single channel");

   property p_fault_set;
      expired |=> o_fault_latched && !o_torque_enable;
   endproperty
   a_fault_set: assert property (p_fault_set)
      else $error("fault latch not set after discrepancy");

   property p_fault_blocks;
      o_fault_latched ##1 start_edge |=> !o_running;
   endproperty
   a_fault_blocks: assert property (p_fault_blocks)
      else $error("motor started with fault latched");

   property p_fault_reports;
      o_fault_latched |-> o_torque_removal_trip && !o_confirm_output_pos;
   endproperty
   a_fault_reports: assert property (p_fault_reports)
      else $error("fault latched without trip or with confirm");

   property p_fault_sticky;
      o_fault_latched |=> o_fault_latched;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky)
      else $error("fault latch cleared without power cycle");

   property p_pair_confirm;
      none_present && !cur.slow_pair && !cur.fault && !expired
      |=> o_confirm_output_pos && o_confirm_output_neg;
   endproperty
   a_pair_confirm: assert property (p_pair_confirm)
      else $error("paired withdrawal not confirmed");

   property p_none_no_run;
      none_present [*2] |-> !o_torque_enable;
   endproperty
   a_none_no_run: assert property (p_none_no_run)
      else $error("torque enabled with both channels withdrawn");

   property p_restore_drops;
      both_present |=> !o_confirm_output_pos;
   endproperty
   a_restore_drops: assert property (p_restore_drops)
      else $error("confirm held after restoration");

   property p_stop_decel;
      o_running && !i_run_cmd && both_present && !expired
      |=> (cur.state == dcto_pkg::ST_DECEL) && o_torque_enable &&
         !o_confirm_output_pos;
   endproperty
   a_stop_decel: assert property (p_stop_decel)
      else $error("stop did not decelerate");

   property p_trip_persists;
      o_torque_removal_trip && !start_edge |=> o_torque_removal_trip;
   endproperty
   a_trip_persists: assert property (p_trip_persists)
      else $error("trip cleared without start command");

   property p_shutdown_time;
      o_torque_enable && $fell(i_demand_channel_a)
      |-> ##[1:4] !o_torque_enable;
   endproperty
   a_shutdown_time: assert property (p_shutdown_time)
      else $error("torque removal too slow");

   property p_shutdown_time_b;
      o_torque_enable && $fell(i_demand_channel_b)
      |-> ##[1:4] !o_torque_enable;
   endproperty
   a_shutdown_time_b: assert property (p_shutdown_time_b)
      else $error("torque removal too slow on channel b");

   property p_slow_no_confirm;
      cur.slow_pair && !both_present |=> !o_confirm_output_pos &&
         !o_confirm_output_neg;
   endproperty
   a_slow_no_confirm: assert property (p_slow_no_confirm)
      else $error("confirm asserted after late second withdrawal");

   property p_start_speed;
      may_start && !expired
      |=> o_speed_ref == $past(i_test_speed_setpoint);
   endproperty
   a_start_speed: assert property (p_start_speed)
      else $error("restart not at setpoint");

   property p_decel_rest;
      (cur.state == dcto_pkg::ST_DECEL) && !start_edge && both_present &&
         !expired && (o_speed_ref <= RAMP_STEP)
      |=> !o_torque_enable && (o_speed_ref == `DCTO_SPEED_RST);
   endproperty
   a_decel_rest: assert property (p_decel_rest)
      else $error("deceleration did not end at rest");

   c_run: cover property (may_start ##1 o_running);
   c_slow: cover property ((mismatch && over_window) ##1 none_present);
   c_paired: cover property (o_running ##1 none_present ##2
      o_confirm_output_pos);
   c_fault: cover property (o_running ##1 mismatch ##[1:1000]
      o_fault_latched);
   c_decel: cover property ((cur.state == dcto_pkg::ST_DECEL) ##1
      (cur.state == dcto_pkg::ST_IDLE));

endmodule : dual_channel_torque_off_monitor

/* File: src/dcto_params.svh */
`ifndef DCTO_PARAMS_SVH
`define DCTO_PARAMS_SVH

// ========================================
// clock and timing
`define DCTO_CLK_HZ 64'd40000000
`define DCTO_PAIR_WINDOW_MS 64'd1000
`define DCTO_DISCREPANCY_MS 64'd3000
`define DCTO_SHUTDOWN_MAX_MS 64'd10
`define DCTO_MS_TO_CYCLES(ms) (((ms) * `DCTO_CLK_HZ) / 64'd1000)
`define DCTO_PAIR_WINDOW_CYCLES `DCTO_MS_TO_CYCLES(`DCTO_PAIR_WINDOW_MS)
`define DCTO_DISCREPANCY_CYCLES `DCTO_MS_TO_CYCLES(`DCTO_DISCREPANCY_MS)
`define DCTO_SHUTDOWN_MAX_CYCLES `DCTO_MS_TO_CYCLES(`DCTO_SHUTDOWN_MAX_MS)

// ========================================
// widths and reset values
`define DCTO_SPEED_W 16
`define DCTO_SPEED_RST 16'h0000
`define DCTO_RAMP_STEP 16'h0001
`define DCTO_SYNC_STAGES 2

`endif

/* File: src/dcto_pkg.sv */
`include "dcto_params.svh"

package dcto_pkg;

   // ========================================
   // drive sequencer states, gray along idle-run-decel
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_RUN = 3'h1,
      ST_DECEL = 3'h3,
      ST_TRIP = 3'h2,
      ST_FAULT = 3'h6
   } drive_state_t;

   // ========================================
   // complete state of the monitor
   typedef struct packed
   {
      drive_state_t state;
      logic trip;
      logic fault;
      logic slow_pair;
      logic confirm;
      logic run_prev;
      logic [`DCTO_SPEED_W-1:0] speed;
   } monitor_t;

endpackage : dcto_pkg

/* File: src/demand_sync.sv */
`timescale 1ns/1ps
`include "dcto_params.svh"

module demand_sync
#(
   parameter int unsigned WIDTH = 2
)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // raw and synchronised levels
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);

   typedef struct packed
   {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_t;

   sync_t cur;
   sync_t next_cur;

   // ========================================
   // per-bit two-stage chain; meta feeds only stable
   always_comb
   begin
      next_cur = cur;
      next_cur.meta = i_async;
      next_cur.stable = cur.meta;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         // idle level of closed contacts: no false withdrawal after reset
         cur <= '1;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         assign o_sync[g] = cur.stable[g];
      end
   endgenerate

endmodule : demand_sync

/* File: src/discrepancy_timer.sv */
`timescale 1ns/1ps
`include "dcto_params.svh"

module discrepancy_timer
#(
   parameter int unsigned WINDOW_CYCLES = 40000000,
   parameter int unsigned LIMIT_CYCLES = 120000000,
   parameter int unsigned CNT_W = $clog2(LIMIT_CYCLES + 1)
)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // channels disagree
   input wire logic i_mismatch,
   // elapsed disagreement
   output logic o_over_window,
   output logic o_expired
);

   typedef struct packed
   {
      logic [CNT_W-1:0] count;
   } timer_t;

   timer_t cur;
   timer_t next_cur;

   // ========================================
   // saturating count, restarts on agreement
   always_comb
   begin
      next_cur = cur;
      if (!i_mismatch)
      begin
         next_cur.count = '0;
      end
      else if (cur.count < CNT_W'(LIMIT_CYCLES))
      begin
         next_cur.count = cur.count + CNT_W'(1);
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign o_over_window = (cur.count > CNT_W'(WINDOW_CYCLES));
   assign o_expired = (cur.count >= CNT_W'(LIMIT_CYCLES));

   property p_count_restart;
      @(posedge i_clk_sys) disable iff (i_rst)
      !i_mismatch |=> (cur.count == '0);
   endproperty
   a_count_restart: assert property (p_count_restart)
      else $error("discrepancy count did not restart on agreement");

endmodule : discrepancy_timer

/* File: verif/safety_ctrl_model.sv */
`timescale 1ns/1ps

// ========================================
// external safety controller: two contact outputs
module safety_ctrl_model
(
   // clock
   input wire logic i_clk_sys,
   // withdrawal requests from the bench
   input wire logic i_drop_a,
   input wire logic i_drop_b,
   // demand contacts, high while closed
   output logic o_demand_a,
   output logic o_demand_b
);
   // both contacts switch on the same edge when both are asked
   always @(posedge i_clk_sys)
   begin
      o_demand_a <= !i_drop_a;
      o_demand_b <= !i_drop_b;
   end
endmodule : safety_ctrl_model

/* File: verif/dual_channel_torque_off_monitor_tb_top.sv */
`timescale 1ns/1ps
`include "dcto_params.svh"

`define CHK(nm, ex, got) \
   begin \
      check_count++; \
      if ((got) !== (ex)) \
      begin \
         failures++; \
         $display("MISMATCH %s exp %h got %h", nm, ex, got); \
      end \
   end

module dual_channel_torque_off_monitor_tb_top;
   localparam logic [15:0] SP1 = 16'h1234;
   logic i_clk_sys;
   logic i_rst;
   logic drop_a;
   logic drop_b;
   logic dem_a;
   logic dem_b;
   logic run;
   logic [15:0] sp;
   logic ten;
   logic [15:0] spd;
   logic rng;
   logic trip;
   logic flt;
   logic cpos;
   logic cneg;
   int failures;
   int check_count;

   safety_ctrl_model ctrl_u (.i_clk_sys(i_clk_sys), .i_drop_a(drop_a),
      .i_drop_b(drop_b), .o_demand_a(dem_a), .o_demand_b(dem_b));

   dual_channel_torque_off_monitor #(.PAIR_WINDOW_CYCLES(20),
      .DISCREPANCY_CYCLES(60), .RAMP_STEP(16'h0100)) dut_u (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_demand_channel_a(dem_a), .i_demand_channel_b(dem_b),
      .i_run_cmd(run), .i_test_speed_setpoint(sp),
      .o_torque_enable(ten), .o_speed_ref(spd), .o_running(rng),
      .o_torque_removal_trip(trip), .o_fault_latched(flt),
      .o_confirm_output_pos(cpos), .o_confirm_output_neg(cneg));

   // ========================================
   // helpers
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask : tick

   // look between edges so design updates have landed
   task status(input logic r, input logic t, input logic c, input logic f);
      @(negedge i_clk_sys);
      `CHK("running", r, rng)
      `CHK("torque", r, ten)
      `CHK("trip", t, trip)
      `CHK("confirm_pos", c, cpos)
      `CHK("confirm_neg", c, cneg)
      `CHK("fault", f, flt)
   endtask : status

   task start;
      tick(1);
      run <= 1'b0;
      tick(2);
      run <= 1'b1;
      tick(3);
   endtask : start

   task power_cycle;
      tick(1);
      i_rst <= 1'b1;
      run <= 1'b0;
      tick(10);
      i_rst <= 1'b0;
      tick(5);
   endtask : power_cycle

   // ========================================
   // scenarios
   task t_run;
      start();
      status(1, 0, 0, 0);
      `CHK("speed", SP1, spd)
      $display("test run done");
   endtask : t_run

   // short single-channel loss, well inside the window
   task t_single(input logic ch);
      tick(1);
      drop_a <= !ch;
      drop_b <= ch;
      tick(5);
      status(0, 1, 0, 0);
      `CHK("speed", 16'h0000, spd)
      tick(4);
      drop_a <= 1'b0;
      drop_b <= 1'b0;
      tick(8);
      status(0, 1, 0, 0);
      start();
      status(1, 0, 0, 0);
      `CHK("speed", SP1, spd)
      $display("test single done");
   endtask : t_single

   // long single-channel loss, then power cycle
   task t_fault(input logic ch);
      tick(1);
      drop_a <= !ch;
      drop_b <= ch;
      tick(75);
      status(0, 1, 0, 1);
      drop_a <= 1'b0;
      drop_b <= 1'b0;
      tick(6);
      start();
      status(0, 1, 0, 1);
      power_cycle();
      status(0, 0, 0, 0);
      start();
      status(1, 0, 0, 0);
      $display("test fault done");
   endtask : t_fault

   // paired withdrawal 10 cycles apart, run held for longer than the limit
   task t_pair;
      tick(1);
      drop_a <= 1'b1;
      tick(10);
      drop_b <= 1'b1;
      tick(6);
      status(0, 1, 1, 0);
      tick(1);
      run <= 1'b0;
      tick(3);
      run <= 1'b1;
      tick(100);
      status(0, 1, 1, 0);
      drop_a <= 1'b0;
      drop_b <= 1'b0;
      tick(5);
      status(0, 1, 0, 0);
      start();
      status(1, 0, 0, 0);
      `CHK("speed", SP1, spd)
      $display("test pair done");
   endtask : t_pair

   // second withdrawal 30 cycles late: no confirm, no fault
   task t_slow;
      tick(1);
      drop_a <= 1'b1;
      tick(30);
      drop_b <= 1'b1;
      tick(8);
      status(0, 1, 0, 0);
      drop_a <= 1'b0;
      drop_b <= 1'b0;
      tick(5);
      status(0, 1, 0, 0);
      start();
      status(1, 0, 0, 0);
      `CHK("speed", SP1, spd)
      $display("test slow pair done");
   endtask : t_slow

   task t_stop;
      tick(1);
      run <= 1'b0;
      tick(3);
      @(negedge i_clk_sys);
      `CHK("decel_torque", 1'b1, ten)
      `CHK("decel_run", 1'b0, rng)
      `CHK("ramping", 1'b1, spd < SP1 && spd != 16'h0000)
      tick(30);
      status(0, 0, 0, 0);
      `CHK("speed", 16'h0000, spd)
      $display("test stop done");
   endtask : t_stop

   // ========================================
   // verdict
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   initial
   begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end

   // whole run is about 500 cycles
   initial
   begin
      tick(5000);
      failures++;
      end_of_test();
   end

   initial
   begin
      failures = 0;
      check_count = 0;
      i_rst = 1'b1;
      drop_a = 1'b0;
      drop_b = 1'b0;
      run = 1'b0;
      sp = SP1;
      tick(10);
      i_rst <= 1'b0;
      tick(5);
      status(0, 0, 0, 0);
      t_run();
      t_single(1'b0);
      t_single(1'b1);
      t_fault(1'b0);
      t_fault(1'b1);
      t_pair();
      t_slow();
      t_stop();
      end_of_test();
   end
endmodule : dual_channel_torque_off_monitor_tb_top
